// file: hdl/rsch_map.vh
`ifndef RSCH_MAP_VH
`define RSCH_MAP_VH
// ----------------------------------------
// Frame bytes and command codes.
// ----------------------------------------
`define RSCH_START_BYTE      8'h02
`define RSCH_CMD_READ_REQ    8'h10
`define RSCH_CMD_WRITE_REQ   8'h11
`define RSCH_CONFIRM_BIT     8'h40
`define RSCH_STATUS_OK       8'h00
`define RSCH_STATUS_FAIL     8'h01
`define RSCH_LEN_HIGH        8'h00
`define RSCH_LEN_READ_REQ    8'h01
`define RSCH_LEN_WRITE_REQ   8'h02
`define RSCH_LEN_WRITE_CNF   8'h01
`define RSCH_LEN_READ_CNF    8'h02
// ----------------------------------------
// Settings indices and reset values.
// ----------------------------------------
`define RSCH_IDX_SCAN        8'h0D
`define RSCH_IDX_BEACON      8'h0E
`define RSCH_IDX_PERSEC      8'h2C
`define RSCH_RST_SCAN        8'h00
`define RSCH_RST_BEACON      8'h00
`define RSCH_RST_PERSEC      8'h0B
// ----------------------------------------
// Field positions and codes.
// ----------------------------------------
`define RSCH_SCAN_ACTIVE_BIT 0
`define RSCH_SEC_MODE_HI     2
`define RSCH_SEC_MODE_LO     0
`define RSCH_SEC_BOND_BIT    3
`define RSCH_SEC_MODE_NONE   3'h0
`define RSCH_SEC_MODE_JUST   3'h2
`define RSCH_SEC_MODE_PASS   3'h3
`define RSCH_BCN_MODE_HI     1
`define RSCH_BCN_MODE_LO     0
`define RSCH_BCN_MODE_ALL    2'h1
`define RSCH_BCN_MODE_FILT   2'h3
`define RSCH_BCN_RSSI_BIT    2
// ----------------------------------------
// Stored bits and confirm byte counts.
// ----------------------------------------
`define RSCH_SCAN_WR_MASK    8'h01
`define RSCH_TX_CNT_SHORT    3'h5
`define RSCH_TX_CNT_LONG     3'h6
`endif

// file: hdl/rsch_settings_handler.v
// Functional notes
// - Peripheral-only security byte at index 44, read/write, resets to 11.
// - Peripheral-only security byte decodes like the general security byte.
// - Successful write answers 02, 51, 01 00, status 00, checksum.
// - Successful read answers 02, 50, 02 00, status 00, value, checksum.
// - Scan behaviour byte at index 13, read/write, resets to 0.
// - Scan bit 0 set gives active scanning while scan runs, else passive.
// - Active scanning sends a scan request to each heard advertiser.
// - Beacon reception in use forces active scanning regardless of bit 0.
// - Scan bits above bit 0 are reserved and have no function.
// - Scan byte reads back zero when active scanning is disabled.
// - Beacon byte at index 14, read/write, resets to 0, disabled.
// - Beacon byte enables reception; options combine by summed weights.
// - Security bits 2:0 mode 0, 2, 3; bit 3 bonding; rest reserved.
// - Beacon bits 1:0 code 1 all or 3 filtered; bit 2 strength report.
`timescale 1ns/1ps
`include "rsch_map.vh"
module rsch_settings_handler (
    input  wire       clk_in,
    input  wire       rst_n_in,
    input  wire [7:0] rx_data_in,
    input  wire       rx_valid_in,
    input  wire       tx_ready_in,
    input  wire       scan_running_in,
    input  wire       adv_heard_in,
    output reg  [7:0] tx_data_out,
    output reg        tx_valid_out,
    output reg        active_scan_out,
    output reg        scan_request_out,
    output reg  [2:0] sec_mode_out,
    output reg        sec_mode_valid_out,
    output reg        bonding_enable_out,
    output reg        beacon_enable_out,
    output reg        beacon_filter_out,
    output reg        signal_strength_enable_out
);

// ----------------------------------------
// Receive parser states.
// ----------------------------------------
localparam [2:0] RX_START = 3'h0;
localparam [2:0] RX_CMD   = 3'h1;
localparam [2:0] RX_LENL  = 3'h2;
localparam [2:0] RX_LENH  = 3'h3;
localparam [2:0] RX_IDX   = 3'h4;
localparam [2:0] RX_PARAM = 3'h5;
localparam [2:0] RX_CS    = 3'h6;
localparam [2:0] RX_WAIT  = 3'h7;

reg  [2:0] rx_state_r;
reg  [7:0] cmd_r;
reg  [7:0] len_r;
reg  [7:0] idx_r;
reg  [7:0] param_r;
reg  [7:0] rx_cs_r;
reg  [7:0] scan_flags_r;
reg  [7:0] beacon_flags_r;
reg  [7:0] persec_flags_r;
reg  [7:0] tx_buf_r [0:5];
reg  [2:0] tx_cnt_r;
reg  [2:0] tx_pos_r;
reg  [7:0] tx_cs_r;
reg  [7:0] rd_value;
reg        idx_known;
wire       cs_good;
wire       is_write;
wire       is_read;
wire       frame_end;
wire       len_ok;
wire       frame_ok;
reg        wr_scan_en;
reg        wr_beacon_en;
reg        wr_persec_en;
reg  [2:0] sec_mode_nxt;
reg        sec_valid_nxt;
reg        bond_nxt;
reg        bcn_enable_nxt;
reg        bcn_filter_nxt;
reg        rssi_enable_nxt;
reg        active_scan_nxt;
reg        scan_request_nxt;

// ----------------------------------------
// Setting lookup.
// ----------------------------------------
always @* begin
    rd_value  = 8'h00;
    idx_known = 1'b1;
    // An unknown index leaves idx_known low, so the confirm carries a failure status.
    case (idx_r)
        `RSCH_IDX_SCAN:   rd_value = scan_flags_r;
        `RSCH_IDX_BEACON: rd_value = beacon_flags_r;
        `RSCH_IDX_PERSEC: rd_value = persec_flags_r;
        default:          idx_known = 1'b0;
    endcase
end

assign is_write  = (cmd_r == `RSCH_CMD_WRITE_REQ);
assign is_read   = (cmd_r == `RSCH_CMD_READ_REQ);
assign cs_good   = (rx_cs_r == rx_data_in);
assign frame_end = rx_valid_in && (rx_state_r == RX_CS);
assign len_ok    = (is_write && len_r == `RSCH_LEN_WRITE_REQ) ||
                   (is_read && len_r == `RSCH_LEN_READ_REQ);
assign frame_ok  = frame_end && cs_good;

// ----------------------------------------
// Receive frame parser.
// ----------------------------------------
always @(posedge clk_in) begin
    if (!rst_n_in) begin
        rx_state_r     <= RX_START;
        cmd_r          <= 8'h00;
        len_r          <= 8'h00;
        idx_r          <= 8'h00;
        param_r        <= 8'h00;
        rx_cs_r        <= 8'h00;
    end else if (rx_state_r == RX_WAIT) begin
        // New bytes are ignored until the last confirm byte has been taken.
        if (tx_cnt_r == 3'h0 && !tx_valid_out) begin
            rx_state_r <= RX_START;
        end
    end else if (rx_valid_in) begin
        rx_cs_r <= rx_cs_r ^ rx_data_in;
        case (rx_state_r)
            RX_START: begin
                rx_cs_r <= rx_data_in;
                if (rx_data_in == `RSCH_START_BYTE) begin
                    rx_state_r <= RX_CMD;
                end
            end
            RX_CMD: begin
                cmd_r      <= rx_data_in;
                rx_state_r <= RX_LENL;
            end
            RX_LENL: begin
                len_r      <= rx_data_in;
                rx_state_r <= RX_LENH;
            end
            RX_LENH: begin
                rx_state_r <= (rx_data_in == `RSCH_LEN_HIGH && len_ok) ? RX_IDX : RX_START;
            end
            RX_IDX: begin
                idx_r      <= rx_data_in;
                rx_state_r <= is_write ? RX_PARAM : RX_CS;
            end
            RX_PARAM: begin
                param_r    <= rx_data_in;
                rx_state_r <= RX_CS;
            end
            RX_CS: begin
                rx_state_r <= cs_good ? RX_WAIT : RX_START;
            end
            default: rx_state_r <= RX_START;
        endcase
    end
end

// ----------------------------------------
// Settings write decode.
// ----------------------------------------
always @* begin
    wr_scan_en   = 1'b0;
    wr_beacon_en = 1'b0;
    wr_persec_en = 1'b0;
    if (frame_ok && is_write) begin
        case (idx_r)
            `RSCH_IDX_SCAN:   wr_scan_en   = 1'b1;
            `RSCH_IDX_BEACON: wr_beacon_en = 1'b1;
            `RSCH_IDX_PERSEC: wr_persec_en = 1'b1;
            default:          wr_scan_en   = 1'b0;
        endcase
    end
end

// ----------------------------------------
// Settings store.
// ----------------------------------------
always @(posedge clk_in) begin
    if (!rst_n_in) begin
        scan_flags_r   <= `RSCH_RST_SCAN;
        beacon_flags_r <= `RSCH_RST_BEACON;
        persec_flags_r <= `RSCH_RST_PERSEC;
    end else begin
        // Reserved scan bits are dropped so that a disabled scan reads back as zero.
        if (wr_scan_en) begin
            scan_flags_r <= param_r & `RSCH_SCAN_WR_MASK;
        end
        if (wr_beacon_en) begin
            beacon_flags_r <= param_r;
        end
        if (wr_persec_en) begin
            persec_flags_r <= param_r;
        end
    end
end

// ----------------------------------------
// Confirmation transmitter.
// ----------------------------------------
always @(posedge clk_in) begin
    if (!rst_n_in) begin
        tx_cnt_r     <= 3'h0;
        tx_pos_r     <= 3'h0;
        tx_cs_r      <= 8'h00;
        tx_data_out  <= 8'h00;
        tx_valid_out <= 1'b0;
        tx_buf_r[0]  <= 8'h00;
        tx_buf_r[1]  <= 8'h00;
        tx_buf_r[2]  <= 8'h00;
        tx_buf_r[3]  <= 8'h00;
        tx_buf_r[4]  <= 8'h00;
        tx_buf_r[5]  <= 8'h00;
    end else if (frame_ok) begin
        tx_buf_r[0] <= `RSCH_START_BYTE;
        tx_buf_r[1] <= cmd_r | `RSCH_CONFIRM_BIT;
        tx_buf_r[2] <= is_write ? `RSCH_LEN_WRITE_CNF : `RSCH_LEN_READ_CNF;
        tx_buf_r[3] <= `RSCH_LEN_HIGH;
        tx_buf_r[4] <= idx_known ? `RSCH_STATUS_OK : `RSCH_STATUS_FAIL;
        tx_buf_r[5] <= rd_value;
        tx_cnt_r    <= (is_write || !idx_known) ? `RSCH_TX_CNT_SHORT : `RSCH_TX_CNT_LONG;
        tx_pos_r    <= 3'h0;
        tx_cs_r     <= 8'h00;
    end else if (tx_valid_out) begin
        // Each byte stands until the host takes it.
        if (tx_ready_in) begin
            tx_valid_out <= 1'b0;
        end
    end else if (tx_cnt_r != 3'h0) begin
        tx_valid_out <= 1'b1;
        if (tx_pos_r == tx_cnt_r) begin
            // The checksum follows the last buffered byte.
            tx_data_out <= tx_cs_r;
            tx_cnt_r    <= 3'h0;
        end else begin
            tx_data_out <= tx_buf_r[tx_pos_r];
            tx_cs_r     <= tx_cs_r ^ tx_buf_r[tx_pos_r];
            tx_pos_r    <= tx_pos_r + 3'h1;
        end
    end
end

// ----------------------------------------
// Setting decode.
// ----------------------------------------
always @* begin
    sec_mode_nxt = persec_flags_r[`RSCH_SEC_MODE_HI:`RSCH_SEC_MODE_LO];
    bond_nxt     = persec_flags_r[`RSCH_SEC_BOND_BIT];
    case (sec_mode_nxt)
        `RSCH_SEC_MODE_NONE: sec_valid_nxt = 1'b1;
        `RSCH_SEC_MODE_JUST: sec_valid_nxt = 1'b1;
        `RSCH_SEC_MODE_PASS: sec_valid_nxt = 1'b1;
        default:             sec_valid_nxt = 1'b0;
    endcase
    case (beacon_flags_r[`RSCH_BCN_MODE_HI:`RSCH_BCN_MODE_LO])
        `RSCH_BCN_MODE_ALL: begin
            bcn_enable_nxt = 1'b1;
            bcn_filter_nxt = 1'b0;
        end
        `RSCH_BCN_MODE_FILT: begin
            bcn_enable_nxt = 1'b1;
            bcn_filter_nxt = 1'b1;
        end
        default: begin
            bcn_enable_nxt = 1'b0;
            bcn_filter_nxt = 1'b0;
        end
    endcase
    rssi_enable_nxt  = beacon_flags_r[`RSCH_BCN_RSSI_BIT];
    // Only bit 0 of the scan byte has a function.
    active_scan_nxt  = scan_running_in &&
                       (scan_flags_r[`RSCH_SCAN_ACTIVE_BIT] || beacon_enable_out);
    scan_request_nxt = active_scan_out && adv_heard_in;
end

// ----------------------------------------
// Decoded setting outputs.
// ----------------------------------------
always @(posedge clk_in) begin
    if (!rst_n_in) begin
        active_scan_out            <= 1'b0;
        scan_request_out           <= 1'b0;
        sec_mode_out               <= 3'h0;
        sec_mode_valid_out         <= 1'b0;
        bonding_enable_out         <= 1'b0;
        beacon_enable_out          <= 1'b0;
        beacon_filter_out          <= 1'b0;
        signal_strength_enable_out <= 1'b0;
    end else begin
        active_scan_out            <= active_scan_nxt;
        scan_request_out           <= scan_request_nxt;
        sec_mode_out               <= sec_mode_nxt;
        sec_mode_valid_out         <= sec_valid_nxt;
        bonding_enable_out         <= bond_nxt;
        beacon_enable_out          <= bcn_enable_nxt;
        beacon_filter_out          <= bcn_filter_nxt;
        signal_strength_enable_out <= rssi_enable_nxt;
    end
end

endmodule // rsch_settings_handler

// file: testbench/rsch_host_model.sv
`timescale 1ns/1ps
module rsch_host_model (
    input  wire       clk_in,
    input  wire [7:0] dev_data_in,
    input  wire       dev_valid_in,
    output reg  [7:0] host_data_out,
    output reg        host_valid_out,
    output reg        host_ready_out = 1'b1
);
    logic [7:0] rsp_q [$];
    reg         slow_r = 1'b0;
    initial begin
        host_data_out  = 8'h00;
        host_valid_out = 1'b0;
    end
    always @(negedge clk_in) host_ready_out <= slow_r ? ~host_ready_out : 1'b1;
    always @(posedge clk_in) if (dev_valid_in && host_ready_out) rsp_q.push_back(dev_data_in);
    task send(input [7:0] b);
        begin
            @(negedge clk_in);
            host_data_out  = b;
            host_valid_out = 1'b1;
        end
    endtask
    // Sends a request frame; a nonzero bad value corrupts the checksum.
    task frame(input wr, input [7:0] idx, input [7:0] par, input [7:0] bad);
        reg [7:0] cs;
        begin
            cs = 8'h02 ^ (wr ? 8'h11 : 8'h10) ^ (wr ? 8'h02 : 8'h01) ^ idx ^ (wr ? par : 8'h00) ^ bad;
            send(8'h02);
            send(wr ? 8'h11 : 8'h10);
            send(wr ? 8'h02 : 8'h01);
            send(8'h00);
            send(idx);
            if (wr)
                send(par);
            send(cs);
            @(negedge clk_in);
            host_valid_out = 1'b0;
            host_data_out  = ~host_data_out;
        end
    endtask
endmodule // rsch_host_model

// file: testbench/rsch_settings_handler_tb.sv
`timescale 1ns/1ps
module rsch_settings_handler_tb;
    localparam [39:0] SEC_V = 40'h02_0300_050F;
    localparam [47:0] BCN_V = 48'h0002_0704_0301;
    reg        clk_in   = 1'b0;
    reg        rst_n_in = 1'b0;
    reg        run      = 1'b0;
    reg        adv      = 1'b0;
    wire [7:0] rxd, txd;
    wire [2:0] mode;
    wire       rxv, txv, rdy, act, sreq, mok, bond, ben, bfl, sse;
    integer    n_fail    = 0;
    integer    cmp_count = 0;
    integer    cyc       = 0;
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            wrap_up;
        end
    end
    rsch_settings_handler u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .rx_data_in(rxd), .rx_valid_in(rxv),
        .tx_ready_in(rdy), .scan_running_in(run), .adv_heard_in(adv), .tx_data_out(txd), .tx_valid_out(txv),
        .active_scan_out(act), .scan_request_out(sreq), .sec_mode_out(mode), .sec_mode_valid_out(mok),
        .bonding_enable_out(bond), .beacon_enable_out(ben), .beacon_filter_out(bfl),
        .signal_strength_enable_out(sse));
    rsch_host_model u_host (.clk_in(clk_in), .dev_data_in(txd), .dev_valid_in(txv), .host_data_out(rxd),
        .host_valid_out(rxv), .host_ready_out(rdy));
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task check(input string what, input [7:0] seen, input [7:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // Sends one request and compares the whole confirm; par is the value written, or the read value expected.
    task xfer(input wr, input [7:0] idx, input [7:0] par, input [7:0] st);
        reg [7:0] e [0:6];
        integer   i, n;
        begin
            n = wr ? 6 : 7;
            e[0] = 8'h02;
            e[1] = wr ? 8'h51 : 8'h50;
            e[2] = wr ? 8'h01 : 8'h02;
            e[3] = 8'h00;
            e[4] = st;
            e[5] = par;
            e[n - 1] = 8'h00;
            for (i = 0; i < n - 1; i = i + 1)
                e[n - 1] = e[n - 1] ^ e[i];
            u_host.frame(wr, idx, par, 8'h00);
            for (i = 0; i < 300 && u_host.rsp_q.size() < n; i = i + 1)
                @(negedge clk_in);
            repeat (3) @(negedge clk_in);
            check("rsp_len", 8'(u_host.rsp_q.size()), 8'(n));
            for (i = 0; i < n; i = i + 1)
                check("rsp_byte", u_host.rsp_q[i], e[i]);
            u_host.rsp_q.delete();
        end
    endtask
    task pulse(input exp);
        begin
            adv = 1'b1;
            @(negedge clk_in);
            adv = 1'b0;
            check("scan_req", {7'h00, sreq}, {7'h00, exp});
        end
    endtask
    task t_reset;
        begin
            xfer(1'b0, 8'h2C, 8'h0B, 8'h00);
            check("sec_rst", {3'h0, mok, bond, mode}, 8'h1B);
            xfer(1'b0, 8'h0E, 8'h00, 8'h00);
        end
    endtask
    task t_sec;
        reg [7:0] v;
        reg       ok;
        integer   i;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                v = SEC_V[8 * i +: 8];
                ok = v[2:0] == 3'h0 || v[2:0] == 3'h2 || v[2:0] == 3'h3;
                xfer(1'b1, 8'h2C, v, 8'h00);
                xfer(1'b0, 8'h2C, v, 8'h00);
                check("sec_dec", {3'h0, mok, bond, mode}, {3'h0, ok, v[3:0]});
            end
        end
    endtask
    task t_bcn;
        reg [7:0] v;
        reg       en;
        integer   i;
        begin
            run = 1'b1;
            for (i = 0; i < 6; i = i + 1) begin
                v = BCN_V[8 * i +: 8];
                en = v[1:0] == 2'h1 || v[1:0] == 2'h3;
                xfer(1'b1, 8'h0E, v, 8'h00);
                xfer(1'b0, 8'h0E, v, 8'h00);
                check("bcn_dec", {5'h00, ben, bfl, sse}, {5'h00, en, v[1:0] == 2'h3, v[2]});
                check("act_bcn", {7'h00, act}, {7'h00, en});
                pulse(en);
            end
        end
    endtask
    task t_scan;
        begin
            xfer(1'b0, 8'h0D, 8'h00, 8'h00);
            xfer(1'b1, 8'h0D, 8'hFE, 8'h00);
            xfer(1'b0, 8'h0D, 8'h00, 8'h00);
            check("act_rsv", {7'h00, act}, 8'h00);
            xfer(1'b1, 8'h0D, 8'h01, 8'h00);
            check("act_on", {7'h00, act}, 8'h01);
            pulse(1'b1);
            run = 1'b0;
            repeat (3) @(negedge clk_in);
            check("act_off", {7'h00, act}, 8'h00);
            pulse(1'b0);
        end
    endtask
    task t_fault;
        begin
            u_host.frame(1'b1, 8'h0D, 8'h00, 8'h5A);
            repeat (40) @(negedge clk_in);
            check("bad_cs", 8'(u_host.rsp_q.size()), 8'h00);
            xfer(1'b0, 8'h0D, 8'h01, 8'h00);
            xfer(1'b1, 8'h20, 8'h00, 8'h01);
            u_host.slow_r = 1'b1;
            xfer(1'b0, 8'h2C, 8'h02, 8'h00);
            u_host.slow_r = 1'b0;
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        @(negedge clk_in);
        rst_n_in = 1'b1;
        @(negedge clk_in);
        t_reset;
        t_sec;
        t_bcn;
        t_scan;
        t_fault;
        wrap_up;
    end
endmodule // rsch_settings_handler_tb

// file: testbench/rsch_sh_assertions.sv
`timescale 1ns/1ps
module rsch_sh_assertions (
    input wire       clk_in,
    input wire       rst_n_in,
    input wire       tx_ready_in,
    input wire       scan_running_in,
    input wire       adv_heard_in,
    input wire [7:0] tx_data_out,
    input wire       tx_valid_out,
    input wire       active_scan_out,
    input wire       scan_request_out
);
    reg  [2:0] pos_r;
    reg  [7:0] cmd_r;
    reg  [7:0] cs_r;
    wire       acc_w  = tx_valid_out && tx_ready_in;
    wire       last_w = pos_r == ((cmd_r == 8'h51) ? 3'd5 : 3'd6);
    wire [7:0] d_w    = tx_data_out;
    // Tracks the byte position and running checksum of confirm frames, taking a 51 frame as 6 bytes and any other as 7.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            pos_r <= 3'd0;
            cmd_r <= 8'h00;
            cs_r  <= 8'h00;
        end else if (acc_w) begin
            pos_r <= last_w ? 3'd0 : pos_r + 3'd1;
            cs_r  <= last_w ? 8'h00 : cs_r ^ d_w;
            if (pos_r == 3'd1)
                cmd_r <= d_w;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence stall_s;
        tx_valid_out && !tx_ready_in;
    endsequence
    tx_hold_a: assert property (stall_s |=> tx_valid_out && $stable(d_w))
        else $error("tx byte moved before taken");
    start_byte_a: assert property (acc_w && pos_r == 3'd0 |-> d_w == 8'h02)
        else $error("bad start byte");
    confirm_cmd_a: assert property (acc_w && pos_r == 3'd1 |-> d_w == 8'h51 || d_w == 8'h50)
        else $error("bad confirm command");
    length_lo_a: assert property (acc_w && pos_r == 3'd2 |-> d_w == ((cmd_r == 8'h51) ? 8'h01 : 8'h02))
        else $error("bad length low byte");
    length_hi_a: assert property (acc_w && pos_r == 3'd3 |-> d_w == 8'h00)
        else $error("bad length high byte");
    frame_sum_a: assert property (acc_w && last_w |-> d_w == cs_r)
        else $error("bad confirm checksum");
    scan_req_a: assert property (scan_request_out == $past(active_scan_out && adv_heard_in))
        else $error("scan request not tied to advert");
    active_gate_a: assert property (active_scan_out |-> $past(scan_running_in))
        else $error("active scan without scan running");
endmodule // rsch_sh_assertions
bind rsch_settings_handler rsch_sh_assertions u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .tx_ready_in(tx_ready_in), .scan_running_in(scan_running_in), .adv_heard_in(adv_heard_in),
    .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out), .active_scan_out(active_scan_out),
    .scan_request_out(scan_request_out));
